// ---- src/sia_consts.svh ----
// constants of the sequence input allocator: offsets, reset values, selector codes
`ifndef SIA_CONSTS_SVH
`define SIA_CONSTS_SVH

// register byte offsets on the axi4-lite bus
`define SIA_OFF_WORD_A 5'h00
`define SIA_OFF_WORD_B 5'h04
`define SIA_OFF_WORD_C 5'h08
`define SIA_OFF_WORD_D 5'h0c
`define SIA_OFF_STATUS 5'h10

// register indices produced by the address decoder
`define SIA_IDX_WORD_A 3'h0
`define SIA_IDX_WORD_D 3'h3
`define SIA_IDX_STATUS 3'h4
`define SIA_IDX_NONE 3'h7

// reset values of the four selection words
`define SIA_RST_WORD_A 16'h2100
`define SIA_RST_WORD_B 16'h6543
`define SIA_RST_WORD_C 16'h8888
`define SIA_RST_WORD_D 16'h8888

// allocation-mode digit of selection word a
`define SIA_MODE_LSB 0
`define SIA_MODE_FREE 4'h1

// selector codes
`define SIA_SEL_ON 4'h7
`define SIA_SEL_OFF 4'h8
`define SIA_SEL_INV_BASE 4'h9

// fixed selectors of the legacy assignment, one digit per logical input
`define SIA_LEGACY_SEL 56'h88888886543210

// per logical input: 1 = active low, 0 = active high (the two overtravel inputs)
`define SIA_ACT_LOW_MASK 14'h3ff3

// status register field positions
`define SIA_STAT_TERM_LSB 0
`define SIA_STAT_LOGIC_LSB 16

`endif

// ---- src/sia_pkg.sv ----
// types of the sequence input allocator
package sia_pkg;
    typedef logic [3:0] sia_sel_t;
    typedef logic [15:0] sia_word_t;
    typedef enum logic [1:0] {
        SIA_RESP_OKAY = 2'b00,
        SIA_RESP_SLVERR = 2'b10,
        SIA_RESP_DECERR = 2'b11
    } sia_resp_t;
endpackage

// ---- src/sia_route.sv ----
// one selector: picks a terminal, a constant, or an inverted terminal
`timescale 1ns/1ps
`default_nettype none
`include "sia_consts.svh"
module sia_route #(
    parameter int NUM_TERM = 7
) (
    input wire sia_pkg::sia_sel_t sel,
    input wire logic [NUM_TERM-1:0] term,
    input wire logic active_low,
    output logic level
);
    import sia_pkg::*;

    // selector decode into a pin level at the input's own polarity
    always_comb begin
        if (sel < 4'(NUM_TERM)) begin
            level = term[sel[2:0]];
        end else if (sel == `SIA_SEL_ON) begin
            level = ~active_low;
        end else if (sel == `SIA_SEL_OFF) begin
            level = active_low;
        end else begin
            level = ~term[3'(sel - `SIA_SEL_INV_BASE)];
        end
    end
endmodule
`default_nettype wire

// ---- src/sia_top.sv ----
// sequence input allocator: seven terminals routed to fourteen logical inputs
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sia_consts.svh"
module sia_top #(
    parameter int NUM_TERM = 7,
    parameter int NUM_LOGIC = 14,
    parameter int ADDR_W = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_TERM-1:0] seq_terminal,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output sia_pkg::sia_resp_t bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output sia_pkg::sia_resp_t rresp,
    output logic rvalid,
    input wire logic rready,
    output logic servo_on_n,
    output logic prop_control_n,
    output logic fwd_overtravel,
    output logic rev_overtravel,
    output logic alarm_reset_n,
    output logic fwd_torque_limit_n,
    output logic rev_torque_limit_n,
    output logic speed_dir_select_n,
    output logic speed_select_a_n,
    output logic speed_select_b_n,
    output logic ctrl_mode_select_n,
    output logic zero_clamp_n,
    output logic pulse_inhibit_n,
    output logic gain_select_n
);
    import sia_pkg::*;

    // refuse sizes the selector code space or the output list cannot serve
    if (NUM_TERM != 7 || NUM_LOGIC != 14 || ADDR_W < 5) begin : g_size_check
        $error("sia_top: unsupported NUM_TERM, NUM_LOGIC or ADDR_W");
    end

    // address decode shared by read and write paths
    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [4:0] a;
        a = addr[4:0];
        if (addr != ADDR_W'(a)) begin
            reg_index = `SIA_IDX_NONE;
        end else if (a == `SIA_OFF_WORD_A) begin
            reg_index = `SIA_IDX_WORD_A;
        end else if (a == `SIA_OFF_WORD_B) begin
            reg_index = 3'h1;
        end else if (a == `SIA_OFF_WORD_C) begin
            reg_index = 3'h2;
        end else if (a == `SIA_OFF_WORD_D) begin
            reg_index = `SIA_IDX_WORD_D;
        end else if (a == `SIA_OFF_STATUS) begin
            reg_index = `SIA_IDX_STATUS;
        end else begin
            reg_index = `SIA_IDX_NONE;
        end
    endfunction

    // ---- terminal synchroniser ----
    logic [NUM_TERM-1:0] term_meta_q;
    logic [NUM_TERM-1:0] term_sync_q;

    // two flops before any logic sees a terminal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_meta_q <= '0;
            term_sync_q <= '0;
        end else begin
            term_meta_q <= seq_terminal;
            term_sync_q <= term_meta_q;
        end
    end

    // ---- selection words and axi4-lite slave ----
    sia_word_t sel_word_q [4];
    sia_word_t sel_word_d [4];
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    sia_resp_t bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    sia_resp_t rresp_q, rresp_d;
    logic [NUM_LOGIC-1:0] logic_q, logic_d;

    // write path: address and data taken in either order, response after both
    always_comb begin
        logic [2:0] widx;
        logic [ADDR_W-1:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        widx = `SIA_IDX_NONE;
        wa = awaddr_q;
        wd = wdata_q;
        ws = wstrb_q;
        sel_word_d = sel_word_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = awaddr;
            wa = awaddr;
        end
        if (wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = wdata;
            wstrb_d = wstrb;
            wd = wdata;
            ws = wstrb;
        end
        if (aw_have_d && w_have_d && !bvalid_q) begin
            widx = reg_index(wa);
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            if (widx <= `SIA_IDX_WORD_D) begin
                // byte lanes 0 and 1 carry the sixteen selector bits
                if (ws[0]) begin
                    sel_word_d[widx[1:0]][7:0] = wd[7:0];
                end
                if (ws[1]) begin
                    sel_word_d[widx[1:0]][15:8] = wd[15:8];
                end
                bresp_d = SIA_RESP_OKAY;
            end else if (widx == `SIA_IDX_STATUS) begin
                bresp_d = SIA_RESP_SLVERR; // status is read-only
            end else begin
                bresp_d = SIA_RESP_DECERR;
            end
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    // read path: one read under way, data answered on the same edge that takes arvalid
    always_comb begin
        logic [2:0] ridx;
        ridx = reg_index(araddr);
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = SIA_RESP_OKAY;
            if (ridx <= `SIA_IDX_WORD_D) begin
                rdata_d = {16'h0000, sel_word_q[ridx[1:0]]};
            end else if (ridx == `SIA_IDX_STATUS) begin
                rdata_d = (32'(term_sync_q) << `SIA_STAT_TERM_LSB) | (32'(logic_q) << `SIA_STAT_LOGIC_LSB);
            end else begin
                rdata_d = 32'h0000_0000;
                rresp_d = SIA_RESP_DECERR;
            end
        end
        arready_d = !rvalid_d;
    end

    // bus state and selection words; words come up at their factory values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_word_q[0] <= `SIA_RST_WORD_A;
            sel_word_q[1] <= `SIA_RST_WORD_B;
            sel_word_q[2] <= `SIA_RST_WORD_C;
            sel_word_q[3] <= `SIA_RST_WORD_D;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= SIA_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= SIA_RESP_OKAY;
        end else begin
            sel_word_q <= sel_word_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ---- routing ----
    logic free_mode;
    logic [4*NUM_LOGIC-1:0] free_sel;
    logic [4*NUM_LOGIC-1:0] eff_sel;
    logic [NUM_LOGIC-1:0] routed;
    localparam logic [NUM_LOGIC-1:0] ACT_LOW = `SIA_ACT_LOW_MASK;

    // word a digit 0 picks free routing or the fixed legacy table
    assign free_mode = (sel_word_q[0][`SIA_MODE_LSB +: 4] == `SIA_MODE_FREE);
    // digits in logical order: a1..a3, b0..b3, c0..c3, d0..d2; d3 is reserved
    assign free_sel = {sel_word_q[3][11:0], sel_word_q[2], sel_word_q[1], sel_word_q[0][15:4]};
    assign eff_sel = free_mode ? free_sel : `SIA_LEGACY_SEL;

    // one selector per logical input
    for (genvar i = 0; i < NUM_LOGIC; i++) begin : g_route
        sia_route #(
            .NUM_TERM(NUM_TERM)
        ) u_route (
            .sel(eff_sel[4*i +: 4]),
            .term(term_sync_q),
            .active_low(ACT_LOW[i]),
            .level(routed[i])
        );
    end

    // logical inputs registered so every output leaves a flop
    always_comb begin
        logic_d = routed;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            logic_q <= ACT_LOW; // all inactive during reset
        end else begin
            logic_q <= logic_d;
        end
    end

    // output mapping
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign servo_on_n = logic_q[0];
    assign prop_control_n = logic_q[1];
    assign fwd_overtravel = logic_q[2];
    assign rev_overtravel = logic_q[3];
    assign alarm_reset_n = logic_q[4];
    assign fwd_torque_limit_n = logic_q[5];
    assign rev_torque_limit_n = logic_q[6];
    assign speed_dir_select_n = logic_q[7];
    assign speed_select_a_n = logic_q[8];
    assign speed_select_b_n = logic_q[9];
    assign ctrl_mode_select_n = logic_q[10];
    assign zero_clamp_n = logic_q[11];
    assign pulse_inhibit_n = logic_q[12];
    assign gain_select_n = logic_q[13];

    // ---- checks ----
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // free routing follows the servo selector
    free_route_a: assert property (free_mode && sel_word_q[0][7:4] == 4'h3 |=>
        servo_on_n == $past(term_sync_q[3])) else $error("servo input not routed from terminal 3");
    // legacy mode ignores a forced-on servo selector
    legacy_fixed_a: assert property (!free_mode && sel_word_q[0][7:4] == `SIA_SEL_ON |=>
        servo_on_n == $past(term_sync_q[0])) else $error("legacy servo input not from terminal 0");
    // direct code passes the terminal level
    direct_pass_a: assert property (free_mode && sel_word_q[2][3:0] == 4'h6 |=>
        speed_dir_select_n == $past(term_sync_q[6])) else $error("direct code 6 not passed");
    // forced on drives the active level, held over two cycles
    force_on_a: assert property ((free_mode && sel_word_q[0][15:12] == `SIA_SEL_ON) [*2] |->
        fwd_overtravel) else $error("forced-on overtravel not high");
    // forced off drives the inactive level of an active-low input
    force_off_a: assert property (free_mode && sel_word_q[2][7:4] == `SIA_SEL_OFF |=>
        speed_select_a_n) else $error("forced-off input not high");
    // inverted code passes the terminal inverted
    invert_pass_a: assert property (free_mode && sel_word_q[3][7:4] == 4'hf |=>
        pulse_inhibit_n != $past(term_sync_q[6])) else $error("code f not inverted terminal 6");
    // factory values present after reset release
    reset_words_a: assert property ($rose(aresetn) |-> sel_word_q[0] == `SIA_RST_WORD_A &&
        sel_word_q[1] == `SIA_RST_WORD_B && sel_word_q[2] == `SIA_RST_WORD_C &&
        sel_word_q[3] == `SIA_RST_WORD_D) else $error("selection words not at reset values");
    // overtravel follows terminal 3 without inversion in legacy mode
    ot_polarity_a: assert property (!free_mode |=> rev_overtravel == $past(term_sync_q[3]))
        else $error("reverse overtravel polarity wrong");
    // alarm reset and reverse torque limit on their legacy terminals
    legacy_map_a: assert property (!free_mode |=> alarm_reset_n == $past(term_sync_q[4]) &&
        rev_torque_limit_n == $past(term_sync_q[6])) else $error("legacy alarm or torque map wrong");
    // prop control from terminal 1 in legacy mode, one edge later than sync
    prop_map_a: assert property (!free_mode ##1 !free_mode |->
        prop_control_n == $past(term_sync_q[1])) else $error("prop control not from terminal 1");
    // terminal reaches the synchroniser output two edges later
    sync_delay_a: assert property ($past(aresetn, 2) |-> term_sync_q == $past(seq_terminal, 2))
        else $error("terminal synchroniser delay wrong");
    // write response held until taken
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
endmodule
`default_nettype wire

// ---- verif/sequence_input_allocator_test.sv ----
// self-checking bench of the sequence input allocator
`timescale 1ns/1ps
`default_nettype none
`include "sia_consts.svh"
module sequence_input_allocator_test;
    import sia_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [6:0] level_req = 7'h00;
    logic [6:0] seq_terminal;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] rdata;
    sia_resp_t bresp, rresp;
    logic servo_on_n, prop_control_n, fwd_overtravel, rev_overtravel, alarm_reset_n;
    logic fwd_torque_limit_n, rev_torque_limit_n, speed_dir_select_n, speed_select_a_n;
    logic speed_select_b_n, ctrl_mode_select_n, zero_clamp_n, pulse_inhibit_n, gain_select_n;
    logic [13:0] pins;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] seed = 32'd77726;
    logic [33:0] rd_q[$];
    logic [1:0] b_q[$];
    sia_word_t w[4];

    // logical outputs gathered in selector order
    assign pins = {gain_select_n, pulse_inhibit_n, zero_clamp_n, ctrl_mode_select_n, speed_select_b_n,
        speed_select_a_n, speed_dir_select_n, rev_torque_limit_n, fwd_torque_limit_n, alarm_reset_n,
        rev_overtravel, fwd_overtravel, prop_control_n, servo_on_n};

    sia_top sia_top_i (.aclk, .aresetn, .seq_terminal, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .servo_on_n, .prop_control_n, .fwd_overtravel, .rev_overtravel,
        .alarm_reset_n, .fwd_torque_limit_n, .rev_torque_limit_n, .speed_dir_select_n,
        .speed_select_a_n, .speed_select_b_n, .ctrl_mode_select_n, .zero_clamp_n,
        .pulse_inhibit_n, .gain_select_n);

    sia_host_model sia_host_model_i (.aclk(aclk), .level_req(level_req), .seq_terminal(seq_terminal));

    // clock and hang guard
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one selector: direct, forced on, forced off, or inverted
    function automatic logic route(input logic [3:0] s, input logic [6:0] t, input logic lo);
        if (s <= 4'h6) return t[s[2:0]];
        if (s == 4'h7) return !lo;
        if (s == 4'h8) return lo;
        return !t[s - 4'h9];
    endfunction

    function automatic logic [13:0] exp_pins(input logic [6:0] t);
        logic [55:0] sel;
        logic [13:0] e;
        sel = {w[3][11:0], w[2], w[1], w[0][15:4]};
        if (w[0][3:0] != 4'h1) sel = 56'h88888886543210;
        for (int i = 0; i < 14; i++) e[i] = route(sel[4*i +: 4], t, !(i == 2 || i == 3));
        return e;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // bus answers taken off the oldest noted expectation
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            chk({30'h0, rresp}, {30'h0, rd_q[0][33:32]});
            chk(rdata, rd_q[0][31:0]);
            void'(rd_q.pop_front());
        end
        if (bvalid && bready) chk({30'h0, bresp}, {30'h0, b_q.pop_front()});
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        b_q.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'(rnd());
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // write a selection word with noise in the upper half, then read it back
    task automatic set(input int i, input sia_word_t v);
        wr(5'(4*i), {16'(rnd()), v}, 4'hf, SIA_RESP_OKAY);
        w[i] = v;
        rd(5'(4*i), {2'b00, 16'h0, v});
    endtask

    // new terminal levels, then pins and status compared
    task automatic settle_check(input logic [6:0] t);
        level_req <= t;
        repeat (6) @(posedge aclk);
        chk({18'h0, pins}, {18'h0, exp_pins(t)});
        rd(`SIA_OFF_STATUS, {2'b00, 2'h0, exp_pins(t), 9'h0, t});
    endtask

    // reset held twelve edges, idle outputs checked, factory words read back
    task automatic reset_cycle();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        chk({29'h0, awready, wready, arready}, 32'h0);
        chk({18'h0, pins}, {18'h0, `SIA_ACT_LOW_MASK});
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({29'h0, awready, wready, arready}, 32'h7);
        w = '{16'h2100, 16'h6543, 16'h8888, 16'h8888};
        for (int i = 0; i < 4; i++) rd(5'(4*i), {2'b00, 16'h0, w[i]});
    endtask

    initial begin
        reset_cycle();
        for (int k = 0; k < 4; k++) settle_check(7'(rnd()));
        $display("test reset defaults done");
        // every mode digit other than one keeps the fixed assignment
        for (int m = 0; m < 16; m++) begin
            if (m == 1) continue;
            set(0, {12'(rnd()), 4'(m)});
            set(1, 16'(rnd()));
            set(2, 16'(rnd()));
            settle_check(7'(rnd()));
        end
        $display("test legacy mode done");
        // each selector code on every logical input
        for (int c = 0; c < 16; c++) begin
            set(0, {{3{4'(c)}}, 4'h1});
            set(1, {4{4'(c)}});
            set(2, {4{4'(c)}});
            set(3, {4{4'(c)}});
            settle_check(7'(rnd()));
            settle_check(7'(rnd()));
        end
        $display("test code sweep done");
        for (int k = 0; k < 12; k++) begin
            set(0, {12'(rnd()), 4'h1});
            set(1, 16'(rnd()));
            set(2, 16'(rnd()));
            set(3, 16'(rnd()));
            settle_check(7'(rnd()));
        end
        $display("test random routing done");
        // compatible settings of the configuring host, legacy map still rules
        set(0, 16'h8170);
        set(1, 16'h6548);
        settle_check(7'(rnd()));
        $display("test compatible settings done");
        // refused accesses and partial strobes
        rd(5'h14, {SIA_RESP_DECERR, 32'h0});
        wr(5'h1c, 32'h0, 4'hf, SIA_RESP_DECERR);
        wr(`SIA_OFF_STATUS, 32'hffffffff, 4'hf, SIA_RESP_SLVERR);
        wr(`SIA_OFF_WORD_C, 32'hffff1234, 4'h1, SIA_RESP_OKAY);
        w[2] = {w[2][15:8], 8'h34};
        rd(`SIA_OFF_WORD_C, {2'b00, 16'h0, w[2]});
        settle_check(7'(rnd()));
        $display("test bus errors done");
        // mid-run reset brings back the factory words and legacy routing
        reset_cycle();
        settle_check(7'(rnd()));
        $display("test mid-run reset done");
        repeat (4) @(posedge aclk);
        results();
    end
endmodule
`default_nettype wire

// ---- verif/sia_host_model.sv ----
// host controller model that drives the seven sequence terminals
`timescale 1ns/1ps
`default_nettype none
module sia_host_model (
    input wire logic aclk,
    input wire logic [6:0] level_req,
    output logic [6:0] seq_terminal
);
    // terminals follow the request one edge later, like an external driver
    always_ff @(posedge aclk) begin
        seq_terminal <= level_req;
    end
endmodule
`default_nettype wire
